// File: rtl/fdma_pkg.sv
package fdma_pkg;
  // ------------------------------------------------------------
  // command layout
  // ------------------------------------------------------------
  localparam int CMD_WORDS = 5;
  localparam int W_CTRL = 0;
  localparam int W_SRC_LO = 1;
  localparam int W_HI = 2;
  localparam int W_DST_LO = 3;
  localparam int W_COUNT = 4;
  localparam int B_CH = 0;
  localparam int B_DEV = 2;
  localparam int B_DEV_SRC = 3;
  localparam int B_FLYBY = 4;
  localparam int B_WORD = 5;
  localparam int B_PACE_RDY = 6;
  localparam int B_EXPLICIT = 7;
  localparam int JOIN_BITS = 22;
  localparam int LOOP_BITS = 8;
  // ------------------------------------------------------------
  // status codes and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] ST_TC = 4'h1;
  localparam logic [3:0] ST_ABORT = 4'h2;
  localparam logic [3:0] ST_EXCEPT = 4'h3;
  localparam logic [3:0] ST_REJECT = 4'h4;
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [1:0] FLY_NONE = 2'h0;
  localparam logic [1:0] FLY_M2D = 2'h1;
  localparam logic [1:0] FLY_D2M = 2'h2;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [23:0] src;
    logic [23:0] dst;
    logic [15:0] count;
  } fdma_chan_t;

  typedef struct packed {
    logic [23:0] addr;
    logic addr_oe;
    logic rd_n;
    logic wr_n;
    logic [1:0] flyby;
    logic word_size_n;
    logic [3:0] channel_ack_n;
  } fdma_bus_t;
endpackage : fdma_pkg

// File: rtl/fdma_fifo.sv
module fdma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) $error("fdma_fifo: depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr, wr_ptr, next_rd_ptr, next_wr_ptr;
  logic [AW:0] fill, next_fill;
  logic push, pop;

  always_comb begin
    in_ready_o = (fill != (AW+1)'(DEPTH));
    out_valid_o = (fill != '0);
    push = in_valid_i && in_ready_o && ce_i;
    pop = out_valid_o && out_ready_i && ce_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
    out_data_o = mem[rd_ptr];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      fill <= '0;
    end else begin
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
      fill <= next_fill;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : fdma_fifo

// File: rtl/fdma_ctrl.sv
// Behaviour
// - explicit-address accesses stretch until ready input is high
// - command bit picks single-operand or ready pacing for slow devices
// - grant and device requests are sampled; fifo status tracked internally
// - memory-to-memory: block counter, address steps as one 22-bit counter
// - fly-by: nested loop count, low 16 address bits stepped, high address byte held
// - per-device acknowledges come from the io output register
// - read/write strobes and host handshake come from output control lines
// - non-fly-by: operand read into internal register, then written out
// - 24-bit address, 16-bit data, master and slave signalling
// - per-channel source, destination, device and count held internally
// - four independent channels, one per device
// - request low, wait grant low, then master high and request released
// - grant lost while master: release bus, re-request while work pending
// - end, abort, exception or reject: slave mode, status word, host interrupt
// - word size low for word transfers, forced byte unless addresses even
module fdma_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // host slave port
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  output logic cmd_ready_o,
  // data bus, two-way
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  // system bus as master
  output fdma_pkg::fdma_bus_t bus_o,
  input wire logic ready_i,
  // arbitration and host handshake
  output logic bus_request_n_o,
  input wire logic bus_grant_n_i,
  output logic master_active_o,
  output logic host_irq_o,
  // devices
  input wire logic [3:0] channel_request_i,
  input wire logic transfer_abort_n_i
);
  // ------------------------------------------------------------
  // command fifo and staging
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_REQ, S_RD, S_WR, S_FLY} fdma_state_t;
  fdma_state_t state, next_state;
  fdma_pkg::fdma_chan_t slot [4];
  fdma_pkg::fdma_chan_t next_slot [4];
  logic [3:0] pend, next_pend, req_s, next_req_s;
  logic gnt_s, abt_s, wr_d, next_wr_d, irq, next_irq, pop, f_valid;
  logic [15:0] stage [fdma_pkg::CMD_WORDS];
  logic [15:0] next_stage [fdma_pkg::CMD_WORDS];
  logic [2:0] widx, next_widx;
  logic [1:0] cur, next_cur;
  logic [15:0] opnd, next_opnd, status, next_status, f_data;
  logic host_wr, host_rd;
  fdma_pkg::fdma_chan_t c;

  assign host_wr = !cs_n_i && !wr_n_i && wr_d && !master_active_o;
  assign host_rd = !cs_n_i && !rd_n_i && !master_active_o;

  fdma_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .in_valid_i(host_wr),
    .in_ready_o(cmd_ready_o),
    .in_data_i(data_i),
    .out_valid_o(f_valid),
    .out_ready_i(pop),
    .out_data_o(f_data)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic word_ok(fdma_pkg::fdma_chan_t ch);
    return ch.ctrl[fdma_pkg::B_WORD] && !ch.src[0] && !ch.dst[0];
  endfunction

  // explicit address, or a device paced by ready
  function automatic logic need_rdy(fdma_pkg::fdma_chan_t ch, logic dev_phase);
    return !dev_phase || ch.ctrl[fdma_pkg::B_EXPLICIT] || ch.ctrl[fdma_pkg::B_PACE_RDY];
  endfunction

  function automatic logic [23:0] step_addr(logic [23:0] a, logic fly, logic wd);
    logic [23:0] inc;
    inc = wd ? 24'h000002 : 24'h000001;
    if (fly) begin
      return {a[23:16], a[15:0] + inc[15:0]};
    end
    return {a[23:22], a[21:0] + inc[21:0]};
  endfunction

  assign c = slot[cur];

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    logic dev_src, dev, fly, wd, phase_dev, waiting, done, ovf, found;
    logic [15:0] cnt;
    fdma_pkg::fdma_chan_t n;
    next_state = state;
    next_slot = slot;
    next_pend = pend;
    next_stage = stage;
    next_widx = widx;
    next_cur = cur;
    next_opnd = opnd;
    next_status = status;
    next_irq = irq;
    next_req_s = channel_request_i;
    next_wr_d = wr_n_i;
    pop = 1'b0;
    found = 1'b0;
    n = c;
    dev = c.ctrl[fdma_pkg::B_DEV];
    dev_src = c.ctrl[fdma_pkg::B_DEV_SRC];
    fly = c.ctrl[fdma_pkg::B_FLYBY];
    wd = word_ok(c);
    phase_dev = (state == S_RD) ? dev && dev_src : (state == S_WR) ? dev && !dev_src : 1'b0;
    waiting = need_rdy(c, phase_dev) && !ready_i;
    cnt = c.count - 16'h0001;
    done = 1'b0;
    ovf = 1'b0;
    if (host_rd) begin
      next_irq = 1'b0;
    end
    if (widx != 3'(fdma_pkg::CMD_WORDS) && f_valid) begin
      pop = 1'b1;
      next_stage[widx] = f_data;
      next_widx = widx + 3'h1;
    end
    case (state)
      S_IDLE: begin
        if (widx == 3'(fdma_pkg::CMD_WORDS)) begin
          n.ctrl = stage[fdma_pkg::W_CTRL];
          n.src = {stage[fdma_pkg::W_HI][7:0], stage[fdma_pkg::W_SRC_LO]};
          n.dst = {stage[fdma_pkg::W_HI][15:8], stage[fdma_pkg::W_DST_LO]};
          n.count = stage[fdma_pkg::W_COUNT];
          if ((n.ctrl[fdma_pkg::B_FLYBY] && !n.ctrl[fdma_pkg::B_DEV]) || n.count == '0) begin
            next_status = {fdma_pkg::ST_REJECT, 10'h000, n.ctrl[1:0]};
            next_irq = 1'b1;
            next_widx = '0;
          end else if (!pend[n.ctrl[1:0]]) begin
            next_slot[n.ctrl[1:0]] = n;
            next_pend[n.ctrl[1:0]] = 1'b1;
            next_widx = '0;
          end
        end
        for (int i = 0; i < 4; i++) begin
          if (!found && pend[i] && (!slot[i].ctrl[fdma_pkg::B_DEV] || req_s[i])) begin
            found = 1'b1;
            next_cur = 2'(i);
          end
        end
        if (found) begin
          next_state = S_REQ;
        end
      end
      S_REQ: begin
        // grant must stand low on two samples running, so one left over from the last tenure is not taken
        if (!gnt_s && !bus_grant_n_i) begin
          next_irq = 1'b0;
          next_state = fly ? S_FLY : S_RD;
        end
      end
      S_RD, S_WR, S_FLY: begin
        if (gnt_s) begin
          next_state = S_IDLE;
        end else if (abt_s) begin
          next_pend[cur] = 1'b0;
          next_status = {fdma_pkg::ST_ABORT, 10'h000, cur};
          next_irq = 1'b1;
          next_state = S_IDLE;
        end else if (!waiting) begin
          if (state == S_RD) begin
            next_opnd = data_i;
            next_state = S_WR;
          end else begin
            done = 1'b1;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    if (done) begin
      n.count = cnt;
      if (fly) begin
        // loop counter in the low byte, outer count on the stack byte
        n.count[fdma_pkg::LOOP_BITS-1:0] = c.count[fdma_pkg::LOOP_BITS-1:0] - 8'h01;
        if (c.count[fdma_pkg::LOOP_BITS-1:0] == '0) begin
          n.count[15:fdma_pkg::LOOP_BITS] = c.count[15:fdma_pkg::LOOP_BITS] - 8'h01;
        end
        if (dev_src) begin
          n.dst = step_addr(c.dst, 1'b1, wd);
        end else begin
          n.src = step_addr(c.src, 1'b1, wd);
        end
      end else begin
        if (!dev || !dev_src || c.ctrl[fdma_pkg::B_EXPLICIT]) begin
          n.src = step_addr(c.src, dev, wd);
        end
        if (!dev || dev_src || c.ctrl[fdma_pkg::B_EXPLICIT]) begin
          n.dst = step_addr(c.dst, dev, wd);
        end
        ovf = !dev && (n.src[21:0] < c.src[21:0] || n.dst[21:0] < c.dst[21:0]);
      end
      next_slot[cur] = n;
      if (cnt == '0 || ovf) begin
        next_pend[cur] = 1'b0;
        next_status = {ovf && cnt != '0 ? fdma_pkg::ST_EXCEPT : fdma_pkg::ST_TC, 10'h000, cur};
        next_irq = 1'b1;
        next_state = S_IDLE;
      end else if (dev && (!c.ctrl[fdma_pkg::B_PACE_RDY] || !req_s[cur])) begin
        next_state = S_IDLE;
      end else begin
        next_state = fly ? S_FLY : S_RD;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= S_IDLE;
      for (int i = 0; i < 4; i++) begin
        slot[i] <= '0;
      end
      pend <= '0;
      for (int i = 0; i < fdma_pkg::CMD_WORDS; i++) begin
        stage[i] <= '0;
      end
      widx <= '0;
      cur <= '0;
      opnd <= '0;
      status <= fdma_pkg::STATUS_RST;
      irq <= 1'b0;
      req_s <= '0;
      gnt_s <= 1'b1;
      abt_s <= 1'b0;
      wr_d <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      slot <= next_slot;
      pend <= next_pend;
      stage <= next_stage;
      widx <= next_widx;
      cur <= next_cur;
      opnd <= next_opnd;
      status <= next_status;
      irq <= next_irq;
      req_s <= next_req_s;
      gnt_s <= bus_grant_n_i;
      abt_s <= !transfer_abort_n_i;
      wr_d <= next_wr_d;
    end
  end

  // ------------------------------------------------------------
  // output control lines and io output register
  // ------------------------------------------------------------
  logic mst;
  assign mst = (state == S_RD) || (state == S_WR) || (state == S_FLY);
  assign master_active_o = mst;
  assign bus_request_n_o = !(state == S_REQ);
  assign host_irq_o = irq;
  assign data_o = mst ? opnd : status;
  assign data_oe_o = (state == S_WR) || host_rd;
  always_comb begin
    bus_o.addr = (state == S_WR || (state == S_FLY && c.ctrl[fdma_pkg::B_DEV_SRC])) ? c.dst : c.src;
    bus_o.addr_oe = mst;
    bus_o.rd_n = !(state == S_RD || state == S_FLY);
    bus_o.wr_n = !(state == S_WR || state == S_FLY);
    bus_o.flyby = (state != S_FLY) ? fdma_pkg::FLY_NONE
                : c.ctrl[fdma_pkg::B_DEV_SRC] ? fdma_pkg::FLY_D2M : fdma_pkg::FLY_M2D;
    bus_o.word_size_n = !(mst && word_ok(c));
    bus_o.channel_ack_n = 4'hf;
    if (c.ctrl[fdma_pkg::B_DEV] && ((state == S_RD && c.ctrl[fdma_pkg::B_DEV_SRC])
        || (state == S_WR && !c.ctrl[fdma_pkg::B_DEV_SRC]) || state == S_FLY)) begin
      bus_o.channel_ack_n[cur] = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_lost;
    ce_i && master_active_o && gnt_s;
  endsequence
  sequence s_stall;
    ce_i && state == S_RD && !c.ctrl[fdma_pkg::B_DEV] && !ready_i && !gnt_s && !abt_s;
  endsequence
  grant_release_a: assert property ($rose(master_active_o) |-> bus_request_n_o && $past(!bus_request_n_o))
    else $error("master without prior request");
  grant_loss_a: assert property (s_lost |=> !master_active_o)
    else $error("bus kept after grant loss");
  irq_slave_a: assert property ($rose(host_irq_o) |-> !master_active_o)
    else $error("interrupt raised while master");
  ack_slave_a: assert property (!master_active_o |-> bus_o.channel_ack_n == 4'hf)
    else $error("acknowledge in slave mode");
  ready_wait_a: assert property (s_stall |=> state == S_RD && !bus_o.rd_n)
    else $error("read not stretched by ready");
  word_even_a: assert property (!bus_o.word_size_n |-> !bus_o.addr[0])
    else $error("word access on odd address");
  strobe_master_a: assert property ((!bus_o.rd_n || !bus_o.wr_n) |-> master_active_o)
    else $error("strobe outside master mode");
  request_pending_a: assert property (!bus_request_n_o |-> pend != 4'h0)
    else $error("bus request without pending work");
  read_write_a: assert property (ce_i && state == S_RD && ready_i && !gnt_s && !abt_s
      |=> state == S_WR && data_o == $past(data_i))
    else $error("operand not carried to write");
endmodule : fdma_ctrl

// File: test/fdma_far_model.sv
module fdma_far_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // controller side
  input wire fdma_pkg::fdma_bus_t bus_i,
  input wire logic [15:0] data_i,
  input wire logic bus_request_n_i,
  input wire logic master_active_i,
  // bench controls
  input wire logic [3:0] wait_i,
  input wire logic host_take_i,
  // answers
  output logic ready_o,
  output logic [15:0] data_o,
  output logic bus_grant_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [15:0] last_q;
  logic [3:0] cnt_q;
  logic [1:0] strb_q;
  logic acc;
  assign acc = bus_i.addr_oe && !(bus_i.rd_n && bus_i.wr_n);
  // ready is pulled low whenever nothing is selected; every new strobe waits afresh
  assign ready_o = acc && (wait_i == 4'h0
      || (strb_q == {bus_i.rd_n, bus_i.wr_n} && {1'b0, cnt_q} + 5'h01 >= {1'b0, wait_i}));
  // a released data line never keeps its last value
  assign data_o = (acc && !bus_i.rd_n) ? mem[bus_i.addr[6:1]] : ~last_q;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'hc300 + 16'(i);
  end
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 4'h0;
      strb_q <= 2'h3;
      last_q <= 16'h0000;
      bus_grant_n_o <= 1'b1;
    end else begin
      strb_q <= {bus_i.rd_n, bus_i.wr_n};
      cnt_q <= (acc && strb_q == {bus_i.rd_n, bus_i.wr_n}) ? cnt_q + 4'h1 : 4'h0;
      last_q <= data_o;
      if (acc && !bus_i.wr_n && ready_o && bus_i.flyby == fdma_pkg::FLY_NONE) begin
        mem[bus_i.addr[6:1]] <= data_i;
      end
      // the host outranks the controller and may take the bus back at any time
      if (host_take_i) begin
        bus_grant_n_o <= 1'b1;
      end else if (!bus_request_n_i) begin
        bus_grant_n_o <= 1'b0;
      end else if (!master_active_i) begin
        bus_grant_n_o <= 1'b1;
      end
    end
  end
endmodule // fdma_far_model

// File: test/four_channel_dma_controller_tb.sv
`define CHK(g, e, m) \
  comparisons++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("unexpected %0t %s", $time, m); \
  end
module four_channel_dma_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_b = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, take = 1'b0, abort_n = 1'b1, ce = 1'b1;
  logic [15:0] host_data = 16'h0000, data_o, mem_data, data_bus;
  logic [3:0] creq = 4'h0, wait_cyc = 4'h0, ack;
  logic [1:0] fly;
  logic data_oe, ready, req_n, grant_n, master, irq, cmd_ready, ws, m_prev;
  fdma_pkg::fdma_bus_t bus;
  int bad_count = 0, comparisons = 0, cycles = 0, rd_run, rd_max, grants;
  assign data_bus = data_oe ? data_o : (master ? mem_data : host_data);
  fdma_ctrl #(.FIFO_DEPTH(16)) dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .cmd_ready_o(cmd_ready), .data_i(data_bus), .data_o(data_o), .data_oe_o(data_oe), .bus_o(bus),
    .ready_i(ready), .bus_request_n_o(req_n), .bus_grant_n_i(grant_n), .master_active_o(master),
    .host_irq_o(irq), .channel_request_i(creq), .transfer_abort_n_i(abort_n));
  fdma_far_model far (.clk_i(clk), .rst_b_i(rst_b), .bus_i(bus), .data_i(data_bus), .bus_request_n_i(req_n),
    .master_active_i(master), .wait_i(wait_cyc), .host_take_i(take), .ready_o(ready), .data_o(mem_data),
    .bus_grant_n_o(grant_n));
  initial begin
    forever #25 clk = ~clk;
  end
  // ----------------------------------------------------------
  // host and bus helpers
  // ----------------------------------------------------------
  task automatic wr_word(input logic [15:0] w);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    host_data <= w;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask
  task automatic send_cmd(input logic [15:0] c, input logic [23:0] s, input logic [23:0] d, input logic [15:0] n);
    wr_word(c);
    wr_word(s[15:0]);
    wr_word({d[23:16], s[23:16]});
    wr_word(d[15:0]);
    wr_word(n);
  endtask
  task automatic wait_master(input logic v);
    for (int i = 0; i < 60 && master !== v; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // collects what the bus showed until the interrupt rises
  task automatic run_to_irq();
    rd_run = 0;
    rd_max = 0;
    // a tenure already running at the call counts as one
    grants = (master === 1'b1) ? 1 : 0;
    ack = 4'hf;
    fly = 2'h0;
    ws = 1'b1;
    m_prev = master;
    for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
      if (bus.addr_oe === 1'b1) begin
        ack &= bus.channel_ack_n;
        fly |= bus.flyby;
      end
      rd_run = (bus.rd_n === 1'b0) ? rd_run + 1 : 0;
      if (rd_run > 0) ws = bus.word_size_n;
      if (rd_run > rd_max) rd_max = rd_run;
      if (master === 1'b1 && m_prev !== 1'b1) grants++;
      m_prev = master;
    end
    `CHK(irq, 1'b1, "no interrupt")
  endtask
  // reading status must also drop the interrupt
  task automatic chk_status(input logic [3:0] code, input logic [1:0] ch);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(data_oe, 1'b1, "status not driven")
    `CHK(data_o, {code, 10'h000, ch}, "status word")
    `CHK(master, 1'b0, "not slave after event")
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0, "interrupt kept")
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    `CHK({req_n, master, irq, bus.addr_oe}, 4'h8, "slave outputs")
    `CHK(bus.channel_ack_n, 4'hf, "acks")
    `CHK(cmd_ready, 1'b1, "fifo room")
  endtask
  task automatic t_m2m();
    send_cmd(16'h0020, 24'h000010, 24'h000040, 16'h0002);
    for (int i = 0; i < 20 && req_n !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(master, 1'b0, "master before grant")
    wait_master(1'b1);
    `CHK(req_n, 1'b1, "request kept as master")
    run_to_irq();
    `CHK(rd_max, 1, "fast access stretched")
    `CHK({ws, fly, grants}, {1'b0, 2'h0, 32'd1}, "word mode")
    `CHK(far.mem[32], 16'hc308, "first operand")
    `CHK(far.mem[33], 16'hc309, "second operand")
    chk_status(fdma_pkg::ST_TC, 2'h0);
  endtask
  task automatic t_odd();
    send_cmd(16'h0021, 24'h000011, 24'h000040, 16'h0001);
    run_to_irq();
    `CHK(ws, 1'b1, "odd address kept word")
    chk_status(fdma_pkg::ST_TC, 2'h1);
  endtask
  task automatic t_slow();
    wait_cyc <= 4'h3;
    send_cmd(16'h0003, 24'h000004, 24'h000050, 16'h0001);
    run_to_irq();
    `CHK(rd_max inside {[4:6]}, 1'b1, "ready not honoured")
    chk_status(fdma_pkg::ST_TC, 2'h3);
  endtask
  task automatic t_reject();
    send_cmd(16'h0002, 24'h000004, 24'h000050, 16'h0000);
    run_to_irq();
    chk_status(fdma_pkg::ST_REJECT, 2'h2);
  endtask
  task automatic t_take();
    wait_cyc <= 4'h2;
    send_cmd(16'h0000, 24'h000000, 24'h000060, 16'h0006);
    wait_master(1'b1);
    take <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    `CHK({master, irq}, 2'h0, "bus kept after grant lost")
    take <= 1'b0;
    wait_master(1'b1);
    `CHK(master, 1'b1, "no re-request")
    run_to_irq();
    chk_status(fdma_pkg::ST_TC, 2'h0);
  endtask
  task automatic t_fly();
    wait_cyc <= 4'h0;
    send_cmd(16'h005e, 24'h000000, 24'h000020, 16'h0001);
    repeat (5) @(posedge clk);
    #1;
    `CHK(req_n, 1'b1, "request without device")
    creq <= 4'h4;
    run_to_irq();
    creq <= 4'h0;
    `CHK(fly, fdma_pkg::FLY_D2M, "fly-by code")
    `CHK(ack, 4'hb, "channel ack")
    chk_status(fdma_pkg::ST_TC, 2'h2);
  endtask
  task automatic t_single();
    send_cmd(16'h0007, 24'h000008, 24'h000000, 16'h0002);
    creq <= 4'h8;
    run_to_irq();
    creq <= 4'h0;
    `CHK(grants, 2, "single operand pacing")
    `CHK(ack, 4'h7, "channel ack")
    chk_status(fdma_pkg::ST_TC, 2'h3);
  endtask
  task automatic t_abort();
    wait_cyc <= 4'h3;
    send_cmd(16'h004d, 24'h000000, 24'h000030, 16'h0004);
    creq <= 4'h2;
    wait_master(1'b1);
    abort_n <= 1'b0;
    run_to_irq();
    abort_n <= 1'b1;
    creq <= 4'h0;
    chk_status(fdma_pkg::ST_ABORT, 2'h1);
  endtask
  // a low clock enable must hold the access exactly where it stands
  task automatic t_freeze();
    send_cmd(16'h0001, 24'h000020, 24'h000070, 16'h0001);
    wait_master(1'b1);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK({master, bus.rd_n, bus.wr_n, irq}, 4'ha, "state moved while frozen")
    ce <= 1'b1;
    run_to_irq();
    `CHK(far.mem[56], 16'hc310, "operand after freeze")
    chk_status(fdma_pkg::ST_TC, 2'h1);
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    t_reset();
    t_m2m();
    t_odd();
    t_slow();
    t_reject();
    t_take();
    t_fly();
    t_single();
    t_abort();
    t_freeze();
    give_verdict();
  end
endmodule // four_channel_dma_controller_tb
